// ===== rtl/dpo_pkg.sv
package dpo_pkg;
  // Register port geometry.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] GPO_OFS = 8'h04;
  localparam logic [7:0] GPIO_OFS = 8'h08;
  localparam logic [7:0] STAT_OFS = 8'h0C;
  // Control register fields.
  localparam int C_FILT = 0;
  localparam int C_EDGE = 1;
  localparam int C_M18 = 2;
  localparam int C_GPIO = 3;
  localparam int C_AUDB = 4;
  localparam int C_MCLK = 5;
  localparam int CTRL_W = 7;
  localparam logic [6:0] CTRL_RST = 7'h01;
  // Output-level register fields: enables in the low bits, levels above.
  localparam int GPO_N = 5;
  localparam int G_LVL = 8;
  localparam logic [4:0] GPO_RST = 5'h00;
  // General-purpose I/O register fields.
  localparam int GPIO_N = 4;
  localparam int GP_DIR = 4;
  localparam logic [3:0] GPIO_RST = 4'h0;
  // Status register fields.
  localparam int S_LOCK = 4;
  localparam int S_IRQ = 5;
  localparam int S_M18 = 6;
  // Pixel path timing, counted in output pixel clocks.
  localparam int FILT_LEN = 3;
  localparam int FS_GAP = 130;
  localparam logic [7:0] FS_GAP_M1 = 8'(FS_GAP - 1);
  localparam int PIX_W = 24;
  localparam int B0_BIT = 16;
  localparam int B1_BIT = 17;
  // Audio master clock ratio codes.
  localparam logic [1:0] MCLK_X1 = 2'h0;
  localparam logic [1:0] MCLK_X2 = 2'h1;
  localparam logic [1:0] MCLK_X4 = 2'h2;
  localparam int AUD_DIV_W = 3;

  // Maps I/O index 0..3 onto pixel bits 0, 1, 8 and 9.
  function automatic int dpo_gpio_bit(input int i);
    return (i / 2) * 8 + (i % 2);
  endfunction
endpackage

// ===== rtl/dpo_out.sv
`timescale 1ns/1ps
// Contract
// (RQ1) Filter on: sync/valid pulses under three clocks dropped.
// (RQ2) Filter off: sync/valid pass without width limit.
// (RQ3) Line sync, valid: two changes per 130 clocks. Not limited here: only frame sync has a gap counter.
// (RQ4) Frame sync: one change per 130 clocks.
// (RQ5) Register bit picks pixel clock strobe edge.
// (RQ6) Master clock at one, two, four times bit clock.
// (RQ7) Four I/O replace R0,R1,G0,G1 in 18-bit mode.
// (RQ8) Register levels drive B0,B1,audio data, word, bit clock.
// (RQ9) 18-bit mode: B1 pin carries second audio data.
// (RQ10) Power-down low: outputs float, PLL off.
// (RQ11) Shared pin: interrupt or self-test clock select.
// (RQ12) Unlocked: outputs follow enable pin; locked: active.
// (RQ13) Pixel, sync, valid outputs registered together.
module dpo_out (
  // Clock and power-down reset
  input wire logic clk,
  input wire logic resetn,
  // Register port
  input wire logic [dpo_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [dpo_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [dpo_pkg::DATA_W-1:0] reg_rdata,
  // Recovered video and audio
  input wire logic [dpo_pkg::PIX_W-1:0] in_pixel,
  input wire logic in_line_sync,
  input wire logic in_frame_sync,
  input wire logic in_valid,
  input wire logic in_audio_word,
  input wire logic in_audio_data_a,
  input wire logic in_audio_data_b,
  output logic pixel_take,
  // Link state and straps
  input wire logic link_locked,
  input wire logic selftest_en,
  input wire logic cfg_gpio_mode,
  input wire logic cfg_audio_b_mode,
  input wire logic output_enable_pin,
  input wire logic sleep_state_select,
  input wire logic interrupt_input,
  // Video pins
  output logic [dpo_pkg::PIX_W-1:0] pixel_data_out,
  output logic [dpo_pkg::PIX_W-1:0] pixel_data_oe_n,
  input wire logic [dpo_pkg::GPIO_N-1:0] gpio_in,
  output logic line_sync_out,
  output logic frame_sync_out,
  output logic pixel_valid_out,
  output logic pixel_clk_out,
  output logic ctl_oe_n,
  // Audio pins
  output logic audio_bit_clk,
  output logic audio_word_clk,
  output logic audio_data_a,
  output logic audio_mclk,
  output logic audio_oe_n,
  // Miscellaneous
  output logic selftest_clock_select,
  output logic pll_enable
);
  logic [dpo_pkg::CTRL_W-1:0] ctrl, next_ctrl;
  logic [dpo_pkg::GPO_N-1:0] gpo_en, next_gpo_en, gpo_lvl, next_gpo_lvl;
  logic [dpo_pkg::GPIO_N-1:0] gpio_out, next_gpio_out, gpio_dir, next_gpio_dir;
  logic irq, next_irq;
  logic [dpo_pkg::DATA_W-1:0] next_rdata;
  logic filt_on, edge_sel, gpio_mode, audb_mode, hiz;
  logic [1:0] mclk_sel;

  assign filt_on = ctrl[dpo_pkg::C_FILT];
  assign edge_sel = ctrl[dpo_pkg::C_EDGE];
  assign mclk_sel = ctrl[dpo_pkg::C_MCLK+1:dpo_pkg::C_MCLK];
  assign gpio_mode = (ctrl[dpo_pkg::C_M18] & ctrl[dpo_pkg::C_GPIO]) | cfg_gpio_mode; // [RQ7]
  assign audb_mode = (ctrl[dpo_pkg::C_M18] & ctrl[dpo_pkg::C_AUDB]) | cfg_audio_b_mode; // [RQ9]
  // Unlocked with the enable pin low floats the pins unless sleep select holds them low.
  assign hiz = !link_locked && !output_enable_pin && !sleep_state_select; // [RQ12]

  // Register file.
  always_comb
  begin
    next_ctrl = ctrl;
    next_gpo_en = gpo_en;
    next_gpo_lvl = gpo_lvl;
    next_gpio_out = gpio_out;
    next_gpio_dir = gpio_dir;
    next_rdata = '0;
    // A new interrupt level wins over a clear in the same cycle.
    next_irq = irq;
    if (reg_wr)
    begin
      case (reg_addr)
        dpo_pkg::CTRL_OFS: next_ctrl = reg_wdata[dpo_pkg::CTRL_W-1:0];
        dpo_pkg::GPO_OFS:
        begin
          next_gpo_en = reg_wdata[dpo_pkg::GPO_N-1:0];
          next_gpo_lvl = reg_wdata[dpo_pkg::G_LVL+dpo_pkg::GPO_N-1:dpo_pkg::G_LVL];
        end
        dpo_pkg::GPIO_OFS:
        begin
          next_gpio_out = reg_wdata[dpo_pkg::GPIO_N-1:0];
          next_gpio_dir = reg_wdata[dpo_pkg::GP_DIR+dpo_pkg::GPIO_N-1:dpo_pkg::GP_DIR];
        end
        dpo_pkg::STAT_OFS: if (reg_wdata[dpo_pkg::S_IRQ]) next_irq = 1'b0;
        default: next_irq = irq;
      endcase
    end
    if (!selftest_en && interrupt_input)
    begin
      next_irq = 1'b1; // [RQ11]
    end
    if (reg_rd)
    begin
      case (reg_addr)
        dpo_pkg::CTRL_OFS: next_rdata[dpo_pkg::CTRL_W-1:0] = ctrl;
        dpo_pkg::GPO_OFS:
        begin
          next_rdata[dpo_pkg::GPO_N-1:0] = gpo_en;
          next_rdata[dpo_pkg::G_LVL+dpo_pkg::GPO_N-1:dpo_pkg::G_LVL] = gpo_lvl;
        end
        dpo_pkg::GPIO_OFS:
        begin
          next_rdata[dpo_pkg::GPIO_N-1:0] = gpio_out;
          next_rdata[dpo_pkg::GP_DIR+dpo_pkg::GPIO_N-1:dpo_pkg::GP_DIR] = gpio_dir;
        end
        dpo_pkg::STAT_OFS:
        begin
          next_rdata[dpo_pkg::GPIO_N-1:0] = gpio_in; // [RQ7]
          next_rdata[dpo_pkg::S_LOCK] = link_locked;
          next_rdata[dpo_pkg::S_IRQ] = irq;
          next_rdata[dpo_pkg::S_M18] = gpio_mode | audb_mode;
        end
        default: next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ctrl <= dpo_pkg::CTRL_RST;
      gpo_en <= dpo_pkg::GPO_RST;
      gpo_lvl <= dpo_pkg::GPO_RST;
      gpio_out <= dpo_pkg::GPIO_RST;
      gpio_dir <= dpo_pkg::GPIO_RST;
      irq <= 1'b0;
      reg_rdata <= '0;
    end
    else
    begin
      ctrl <= next_ctrl;
      gpo_en <= next_gpo_en;
      gpo_lvl <= next_gpo_lvl;
      gpio_out <= next_gpio_out;
      gpio_dir <= next_gpio_dir;
      irq <= next_irq;
      reg_rdata <= next_rdata;
    end
  end

  // Pixel clock runs at half of clk so the strobe edge picked by the edge bit falls mid-data.
  logic phase, next_phase;
  logic [dpo_pkg::PIX_W-1:0] pipe [dpo_pkg::FILT_LEN];
  logic [dpo_pkg::PIX_W-1:0] next_pipe [dpo_pkg::FILT_LEN];
  logic [dpo_pkg::FILT_LEN-1:0] fs_tap, next_fs_tap;
  logic fs_q, next_fs_q;
  logic [7:0] fs_gap, next_fs_gap;
  logic [1:0] ctl_in, filt_q, next_filt;
  logic [dpo_pkg::FILT_LEN-1:0] tap [2];

  assign ctl_in = {in_valid, in_line_sync};
  assign next_phase = ~phase;

  // Line sync and valid each pass through their own copy of one filter; it only removes edges, never adds them.
  generate
    for (genvar k = 0; k < 2; k++)
    begin : g_filt
      logic [dpo_pkg::FILT_LEN-1:0] next_tap;
      logic next_f;
      always_comb
      begin
        next_tap = tap[k];
        next_f = filt_q[k];
        if (phase)
        begin
          next_tap = {tap[k][dpo_pkg::FILT_LEN-2:0], ctl_in[k]};
          if (!filt_on)
          begin
            next_f = tap[k][dpo_pkg::FILT_LEN-1]; // [RQ2]
          end
          else if (&tap[k])
          begin
            next_f = 1'b1; // [RQ1]
          end
          else if (~|tap[k])
          begin
            next_f = 1'b0; // [RQ1]
          end
        end
      end
      assign next_filt[k] = next_f;
      always_ff @(posedge clk or negedge resetn)
      begin
        if (!resetn)
        begin
          tap[k] <= '0;
          filt_q[k] <= 1'b0;
        end
        else
        begin
          tap[k] <= next_tap;
          filt_q[k] <= next_f;
        end
      end
    end
  endgenerate

  always_comb
  begin
    next_pipe = pipe;
    next_fs_tap = fs_tap;
    next_fs_q = fs_q;
    next_fs_gap = fs_gap;
    if (phase)
    begin
      next_pipe[0] = in_pixel;
      for (int i = 1; i < dpo_pkg::FILT_LEN; i++)
      begin
        next_pipe[i] = pipe[i-1];
      end
      next_fs_tap = {fs_tap[dpo_pkg::FILT_LEN-2:0], in_frame_sync};
      // A frame edge closer than the gap to the last one is held back.
      if (fs_tap[dpo_pkg::FILT_LEN-1] != fs_q && fs_gap == dpo_pkg::FS_GAP_M1)
      begin
        next_fs_q = fs_tap[dpo_pkg::FILT_LEN-1]; // [RQ4]
        next_fs_gap = '0;
      end
      else if (fs_gap != dpo_pkg::FS_GAP_M1)
      begin
        next_fs_gap = fs_gap + 8'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      phase <= 1'b0;
      pipe <= '{default: '0};
      fs_tap <= '0;
      fs_q <= 1'b0;
      fs_gap <= dpo_pkg::FS_GAP_M1;
    end
    else
    begin
      phase <= next_phase;
      pipe <= next_pipe;
      fs_tap <= next_fs_tap;
      fs_q <= next_fs_q;
      fs_gap <= next_fs_gap;
    end
  end

  // Output stage: every pin value and enable leaves from a flip-flop.
  localparam int AUDW = dpo_pkg::AUD_DIV_W;
  logic [AUDW-1:0] aud_cnt, next_aud_cnt;
  logic aud_b, next_aud_b;
  logic [dpo_pkg::PIX_W-1:0] next_pix, next_pix_oe_n;
  logic next_ls, next_fs, next_dv, next_pclk, next_bclk, next_wc, next_da, next_mclk;

  always_comb
  begin
    next_aud_cnt = aud_cnt + 3'h1;
    next_aud_b = in_audio_data_b;
    next_pix = phase ? pipe[dpo_pkg::FILT_LEN-1] : pixel_data_out; // [RQ13]
    next_ls = phase ? next_filt[0] : line_sync_out;
    next_dv = phase ? next_filt[1] : pixel_valid_out;
    next_fs = phase ? next_fs_q : frame_sync_out;
    next_pclk = phase ? edge_sel : ~edge_sel; // [RQ5]
    for (int i = 0; i < dpo_pkg::GPIO_N; i++)
    begin
      if (gpio_mode)
      begin
        next_pix[dpo_pkg::dpo_gpio_bit(i)] = gpio_out[i]; // [RQ7]
      end
    end
    if (audb_mode)
    begin
      next_pix[dpo_pkg::B1_BIT] = aud_b; // [RQ9]
    end
    if (gpo_en[0])
    begin
      next_pix[dpo_pkg::B0_BIT] = gpo_lvl[0]; // [RQ8]
    end
    if (gpo_en[1])
    begin
      next_pix[dpo_pkg::B1_BIT] = gpo_lvl[1]; // [RQ8]
    end
    next_da = gpo_en[2] ? gpo_lvl[2] : in_audio_data_a; // [RQ8]
    next_wc = gpo_en[3] ? gpo_lvl[3] : in_audio_word; // [RQ8]
    next_bclk = gpo_en[4] ? gpo_lvl[4] : aud_cnt[2]; // [RQ8]
    case (mclk_sel)
      dpo_pkg::MCLK_X1: next_mclk = aud_cnt[2]; // [RQ6]
      dpo_pkg::MCLK_X2: next_mclk = aud_cnt[1]; // [RQ6]
      default: next_mclk = aud_cnt[0]; // [RQ6]
    endcase
    next_pix_oe_n = {dpo_pkg::PIX_W{hiz}};
    for (int i = 0; i < dpo_pkg::GPIO_N; i++)
    begin
      if (gpio_mode && !hiz)
      begin
        next_pix_oe_n[dpo_pkg::dpo_gpio_bit(i)] = ~gpio_dir[i]; // [RQ7]
      end
    end
    if (!link_locked)
    begin
      next_pix = '0; // [RQ12]
      next_ls = 1'b0;
      next_fs = 1'b0;
      next_dv = 1'b0;
      next_pclk = 1'b0;
      next_bclk = 1'b0;
      next_wc = 1'b0;
      next_da = 1'b0;
      next_mclk = 1'b0;
    end
  end

  // Reset is the power-down pin: every pin floats and the PLL stays off.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      aud_cnt <= '0; // [RQ10]
      aud_b <= 1'b0;
      pixel_data_out <= '0;
      pixel_data_oe_n <= '1;
      line_sync_out <= 1'b0;
      frame_sync_out <= 1'b0;
      pixel_valid_out <= 1'b0;
      pixel_clk_out <= 1'b0;
      ctl_oe_n <= 1'b1;
      audio_bit_clk <= 1'b0;
      audio_word_clk <= 1'b0;
      audio_data_a <= 1'b0;
      audio_mclk <= 1'b0;
      audio_oe_n <= 1'b1;
      selftest_clock_select <= 1'b0;
      pll_enable <= 1'b0;
      pixel_take <= 1'b0;
    end
    else
    begin
      aud_cnt <= next_aud_cnt;
      aud_b <= next_aud_b;
      pixel_data_out <= next_pix;
      pixel_data_oe_n <= next_pix_oe_n;
      line_sync_out <= next_ls;
      frame_sync_out <= next_fs;
      pixel_valid_out <= next_dv;
      pixel_clk_out <= next_pclk;
      ctl_oe_n <= hiz; // [RQ12]
      audio_bit_clk <= next_bclk;
      audio_word_clk <= next_wc;
      audio_data_a <= next_da;
      audio_mclk <= next_mclk;
      audio_oe_n <= hiz;
      selftest_clock_select <= selftest_en & interrupt_input; // [RQ11]
      pll_enable <= 1'b1; // [RQ10]
      pixel_take <= next_phase;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_ls_rise;
    $rose(filt_q[0]) ##0 filt_on;
  endsequence
  a_filter_min_width: assert property (s_ls_rise |=> (filt_q[0] || !filt_on) [*5]) // [RQ1]
    else $error("Filtered line sync pulse shorter than three pixel clocks.");
  a_nofilter_pass: assert property (phase && !filt_on |=> filt_q[0] == $past(tap[0][2])) // [RQ2]
    else $error("Unfiltered line sync did not follow its input.");
  a_frame_gap: assert property ($changed(fs_q) |-> $past(fs_gap) == dpo_pkg::FS_GAP_M1) // [RQ4]
    else $error("Frame sync changed before the minimum gap.");
  a_strobe_edge: assert property ( // [RQ5]
    !phase |-> pixel_clk_out == ($past(edge_sel) && $past(link_locked)))
    else $error("Pixel clock level wrong after a data update.");
  a_mclk_ratio: assert property ( // [RQ6]
    (link_locked && mclk_sel == dpo_pkg::MCLK_X4) [*2] |=> audio_mclk != $past(audio_mclk))
    else $error("Master clock not at four times rate.");
  a_gpio_drive: assert property ( // [RQ7]
    gpio_mode && gpio_dir[0] && link_locked
    |=> !pixel_data_oe_n[0] && pixel_data_out[0] == $past(gpio_out[0]))
    else $error("General I/O bit 0 not driven from its register.");
  a_gpo_level: assert property ( // [RQ8]
    gpo_en[4] && link_locked |=> audio_bit_clk == $past(gpo_lvl[4]))
    else $error("Bit clock pin not taken from its level register.");
  a_audio_b: assert property ( // [RQ9]
    audb_mode && !gpo_en[1] && link_locked |=> pixel_data_out[dpo_pkg::B1_BIT] == $past(aud_b))
    else $error("B1 pin not carrying second audio data.");
  a_unlock_float: assert property ( // [RQ12]
    hiz |=> pixel_data_oe_n == '1 && ctl_oe_n && audio_oe_n)
    else $error("Outputs driven while unlocked and disabled.");
  a_shared_pin: assert property ( // [RQ11]
    !selftest_en && interrupt_input |=> irq ##0 !selftest_clock_select)
    else $error("Interrupt input not latched outside self-test.");
endmodule

// ===== verif/dpo_sink.sv
`timescale 1ns/1ps
// Display-side model that takes the pixel bus on the strobe edge it is configured for.
module dpo_sink (
  // Clock
  input wire logic clk,
  // Video pins and the panel's own strobe setting
  input wire logic [dpo_pkg::PIX_W-1:0] pixel_data_out,
  input wire logic pixel_clk_out,
  input wire logic edge_sel,
  // Counts for the bench
  output int strobes,
  output int late_changes
);
  logic [dpo_pkg::PIX_W-1:0] prev_pix;
  logic prev_pclk;
  logic strobe;
  initial
  begin
    strobes = 0;
    late_changes = 0;
  end
  // Edges are found from the pin level one clk earlier, so the pin is assumed glitch free.
  assign strobe = edge_sel ? (prev_pclk & ~pixel_clk_out) : (~prev_pclk & pixel_clk_out);
  always @(posedge clk)
  begin
    prev_pclk <= pixel_clk_out;
    prev_pix <= pixel_data_out;
    if (strobe === 1'b1)
      strobes <= strobes + 1;
    if (strobe === 1'b1 && pixel_data_out !== prev_pix)
      late_changes <= late_changes + 1;
  end
endmodule

// ===== verif/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0, reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [23:0] in_pixel = 24'h0;
  logic in_line_sync = 1'b0, in_frame_sync = 1'b0, in_valid = 1'b0;
  logic in_audio_word = 1'b0, in_audio_data_a = 1'b0, in_audio_data_b = 1'b0;
  logic link_locked = 1'b1, selftest_en = 1'b0, cfg_gpio_mode = 1'b0, cfg_audio_b_mode = 1'b0;
  logic output_enable_pin = 1'b1, sleep_state_select = 1'b0, interrupt_input = 1'b0;
  logic [3:0] gpio_in = 4'hA;
  logic edge_cfg = 1'b0;
  logic [23:0] pixel_data_out, pixel_data_oe_n;
  logic pixel_take, line_sync_out, frame_sync_out, pixel_valid_out, pixel_clk_out, ctl_oe_n;
  logic audio_bit_clk, audio_word_clk, audio_data_a, audio_mclk, audio_oe_n;
  logic selftest_clock_select, pll_enable;
  int strobes, late_changes;
  int err_total = 0;
  int samples_checked = 0;

  always #10 clk = ~clk;

  dpo_out dut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .in_pixel(in_pixel),
    .in_line_sync(in_line_sync), .in_frame_sync(in_frame_sync), .in_valid(in_valid),
    .in_audio_word(in_audio_word), .in_audio_data_a(in_audio_data_a),
    .in_audio_data_b(in_audio_data_b), .pixel_take(pixel_take), .link_locked(link_locked),
    .selftest_en(selftest_en), .cfg_gpio_mode(cfg_gpio_mode),
    .cfg_audio_b_mode(cfg_audio_b_mode), .output_enable_pin(output_enable_pin),
    .sleep_state_select(sleep_state_select), .interrupt_input(interrupt_input),
    .pixel_data_out(pixel_data_out), .pixel_data_oe_n(pixel_data_oe_n), .gpio_in(gpio_in),
    .line_sync_out(line_sync_out), .frame_sync_out(frame_sync_out),
    .pixel_valid_out(pixel_valid_out), .pixel_clk_out(pixel_clk_out), .ctl_oe_n(ctl_oe_n),
    .audio_bit_clk(audio_bit_clk), .audio_word_clk(audio_word_clk),
    .audio_data_a(audio_data_a), .audio_mclk(audio_mclk), .audio_oe_n(audio_oe_n),
    .selftest_clock_select(selftest_clock_select), .pll_enable(pll_enable));

  dpo_sink sink (.clk(clk), .pixel_data_out(pixel_data_out), .pixel_clk_out(pixel_clk_out),
    .edge_sel(edge_cfg), .strobes(strobes), .late_changes(late_changes));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so they are sampled just inside it.
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, exp);
  endtask

  // The 300-clk tail keeps sync pulses far apart, as the link allows only two edges per window.
  task automatic pulse(input int len, input logic fs, input int ls_exp, input bit exact);
    int ls_n, vd_n, fs_n;
    ls_n = 0;
    vd_n = 0;
    fs_n = 0;
    in_line_sync <= 1'b1;
    in_valid <= 1'b1;
    in_frame_sync <= fs;
    repeat (2 * len) @(posedge clk);
    in_line_sync <= 1'b0;
    in_valid <= 1'b0;
    in_frame_sync <= 1'b0;
    repeat (300)
    begin
      @(posedge clk);
      #1;
      ls_n += int'(line_sync_out);
      vd_n += int'(pixel_valid_out);
      fs_n += int'(frame_sync_out);
    end
    check(exact ? 32'(ls_n) : 32'(ls_n > 0), 32'(ls_exp));
    check(exact ? 32'(vd_n) : 32'(vd_n > 0), 32'(ls_exp));
    if (fs)
      check(32'(fs_n >= 2 * dpo_pkg::FS_GAP), 32'h1);
  endtask

  task automatic mclk_ratio(input int code);
    int mr, br;
    logic pm, pb;
    mr = 0;
    br = 0;
    wr(dpo_pkg::CTRL_OFS, (32'(code) << dpo_pkg::C_MCLK) | 32'h1);
    // One settling cycle lets the new ratio reach the pin before counting starts.
    @(posedge clk);
    #1;
    pm = audio_mclk;
    pb = audio_bit_clk;
    repeat (64)
    begin
      @(posedge clk);
      #1;
      mr += int'(audio_mclk & ~pm);
      br += int'(audio_bit_clk & ~pb);
      pm = audio_mclk;
      pb = audio_bit_clk;
    end
    check(32'(br), 32'h8);
    check(32'(mr), 32'h8 << code);
  endtask

  task automatic end_test(input string name);
    $display("test %s done, mismatches so far %0d", name, err_total);
  endtask

  initial
  begin
    #1000000;
    err_total++;
    final_report();
  end

  initial
  begin
    repeat (4) @(posedge clk);
    #1 check(32'(pixel_data_oe_n), 32'hFFFFFF);
    check(32'({ctl_oe_n, audio_oe_n, pll_enable}), 32'h6);
    resetn <= 1'b1;
    rd(dpo_pkg::CTRL_OFS, 32'(dpo_pkg::CTRL_RST));
    rd(8'h40, 32'h0);
    check(32'(pll_enable), 32'h1);
    end_test("reset");
    pulse(1, 1'b0, 0, 1'b1);
    pulse(4, 1'b0, 1, 1'b0);
    wr(dpo_pkg::CTRL_OFS, 32'h0);
    pulse(1, 1'b1, 2, 1'b1);
    end_test("filter");
    for (int e = 0; e < 2; e++)
    begin
      edge_cfg <= e[0];
      wr(dpo_pkg::CTRL_OFS, 32'(e) << dpo_pkg::C_EDGE);
      in_valid <= 1'b1;
      for (int i = 0; i < 20; i++)
      begin
        in_pixel <= 24'(i * 24'h010203);
        repeat (2) @(posedge clk);
      end
      in_valid <= 1'b0;
      repeat (300) @(posedge clk);
    end
    check(32'(late_changes), 32'h0);
    check(32'(strobes > 30), 32'h1);
    end_test("strobe");
    for (int c = 0; c < 3; c++)
      mclk_ratio(c);
    end_test("mclk");
    wr(dpo_pkg::GPO_OFS, 32'h101);
    rd(dpo_pkg::GPO_OFS, 32'h101);
    repeat (4) @(posedge clk);
    #1 check(32'(pixel_data_out[dpo_pkg::B0_BIT]), 32'h1);
    wr(dpo_pkg::GPO_OFS, 32'h0);
    wr(dpo_pkg::CTRL_OFS, 32'h0D);
    wr(dpo_pkg::GPIO_OFS, 32'h11);
    repeat (4) @(posedge clk);
    #1 check(32'({pixel_data_out[0], pixel_data_oe_n[0]}), 32'h2);
    rd(dpo_pkg::STAT_OFS, 32'h5A);
    end_test("gpio");
    wr(dpo_pkg::CTRL_OFS, 32'h1);
    cfg_audio_b_mode <= 1'b1;
    in_audio_data_b <= 1'b1;
    in_audio_word <= 1'b1;
    in_audio_data_a <= 1'b1;
    repeat (8) @(posedge clk);
    #1 check(32'(pixel_data_out[dpo_pkg::B1_BIT]), 32'h1);
    check(32'({audio_word_clk, audio_data_a}), 32'h3);
    in_audio_data_b <= 1'b0;
    in_audio_word <= 1'b0;
    in_audio_data_a <= 1'b0;
    repeat (8) @(posedge clk);
    #1 check(32'(pixel_data_out[dpo_pkg::B1_BIT]), 32'h0);
    check(32'({audio_word_clk, audio_data_a}), 32'h0);
    end_test("audio_b");
    selftest_en <= 1'b1;
    interrupt_input <= 1'b1;
    repeat (3) @(posedge clk);
    #1 check(32'(selftest_clock_select), 32'h1);
    selftest_en <= 1'b0;
    repeat (3) @(posedge clk);
    #1 check(32'(selftest_clock_select), 32'h0);
    interrupt_input <= 1'b0;
    rd(dpo_pkg::STAT_OFS, 32'h7A);
    wr(dpo_pkg::STAT_OFS, 32'h20);
    rd(dpo_pkg::STAT_OFS, 32'h5A);
    end_test("shared_pin");
    link_locked <= 1'b0;
    output_enable_pin <= 1'b0;
    repeat (3) @(posedge clk);
    #1 check(32'({pixel_data_oe_n, ctl_oe_n}), 32'h1FFFFFF);
    sleep_state_select <= 1'b1;
    repeat (3) @(posedge clk);
    #1 check(32'({pixel_data_oe_n, ctl_oe_n}), 32'h0);
    sleep_state_select <= 1'b0;
    output_enable_pin <= 1'b1;
    repeat (3) @(posedge clk);
    #1 check(32'({pixel_data_oe_n, ctl_oe_n}), 32'h0);
    check(32'(pixel_data_out), 32'h0);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    #1 check(32'({pixel_data_oe_n[0], pll_enable}), 32'h2);
    end_test("lock_and_power");
    final_report();
  end
endmodule
